//--- verilog/iopd_pkg.sv
package iopd_pkg;
  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam int unsigned BASE_MSB = 7;
  localparam int unsigned BASE_LSB = 3;
  localparam int unsigned FMT_SEL_BIT = 2;
  localparam logic [1:0] PORT_DMA = 2'h0;
  localparam logic [1:0] PORT_UNUSED = 2'h1;
  localparam logic [1:0] PORT_STATUS = 2'h2;
  localparam logic [1:0] PORT_DRIVE = 2'h3;
  // ----------------------------------------
  // reset values and layouts
  // ----------------------------------------
  localparam logic [7:0] DRIVE_SEL_RST = 8'h00;
  localparam int unsigned STAT_JMP_A_BIT = 0;
  localparam int unsigned STAT_JMP_B_BIT = 1;
  localparam int unsigned STAT_IRQ_BIT = 7;
  localparam int unsigned DRIVE_SELECTS = 4;
endpackage : iopd_pkg

//--- verilog/iopd_decoder.sv
`timescale 1ns/100ps
// Behaviour
// - match when address bits 7..3 equal the strapped base value.
// - block spans eight consecutive ports on an eight-aligned base.
// - match with address bit 2 high selects the formatter chip.
// - match with bit 2 low decodes low bits into ports 0, 2, 3.
// - port zero select is the dma controller chip enable.
// - read and write strobes formed from request with read or write.
// - status byte driven only during read strobe with status port select.
// - write strobe with drive port select loads the drive register.
// - read strobe with drive port select returns the drive register.
// - drive register gives four software controlled drive selects.
// - offsets map dma, unused, status, drive, four formatter registers.
// - status byte holds two jumpers and formatter completion request.
module iopd_decoder #(
  parameter int unsigned DATA_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic io_req_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic [4:0] base_address_strap_i,
  input wire logic config_jumper_a_i,
  input wire logic config_jumper_b_i,
  input wire logic formatter_completion_request_i,
  output logic match_n_o,
  output logic formatter_cs_n_o,
  output logic dma_ce_n_o,
  output logic status_port_select_n_o,
  output logic drive_select_port_select_n_o,
  output logic io_read_strobe_n_o,
  output logic io_write_strobe_n_o,
  output logic formatter_read_enable_n_o,
  output logic formatter_write_enable_n_o,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic [3:0] drive_sel_o
);
  // ----------------------------------------
  // input synchronisers (pins, two stages)
  // ----------------------------------------
  localparam int unsigned SW = 8 + 3 + DATA_W + 5 + 3;
  // idle strobes, all-ones address and a zero strap: no select pulses as reset ends
  localparam logic [SW-1:0] SYNC_IDLE = {{(SW - 8){1'b1}}, 5'h00, 3'h7};
  logic [SW-1:0] s1_r, s2_r, s1_nxt;
  always_comb begin
    s1_nxt = {addr_i, io_req_n_i, rd_n_i, wr_n_i, data_i, base_address_strap_i,
              config_jumper_a_i, config_jumper_b_i, formatter_completion_request_i};
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s1_r <= SYNC_IDLE;
      s2_r <= SYNC_IDLE;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s1_r;
    end
  end
  logic [7:0] a;
  logic req_n, rd_n, wr_n, ja, jb, irq;
  logic [DATA_W-1:0] d;
  logic [4:0] strap;
  assign {a, req_n, rd_n, wr_n, d, strap, ja, jb, irq} = s2_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic match, fmt, p0, p2, p3, io_read_strobe, io_write_strobe;
  logic [7:0] status_byte;
  always_comb begin
    // a five bit compare yields an eight-port window on any aligned base
    match = (a[iopd_pkg::BASE_MSB:iopd_pkg::BASE_LSB] == strap);
    fmt = match && a[iopd_pkg::FMT_SEL_BIT];
    p0 = match && !a[iopd_pkg::FMT_SEL_BIT] && (a[1:0] == iopd_pkg::PORT_DMA);
    p2 = match && !a[iopd_pkg::FMT_SEL_BIT] && (a[1:0] == iopd_pkg::PORT_STATUS);
    p3 = match && !a[iopd_pkg::FMT_SEL_BIT] && (a[1:0] == iopd_pkg::PORT_DRIVE);
    io_read_strobe = !req_n && !rd_n;
    io_write_strobe = !req_n && !wr_n;
    // unused status bits read as zero
    status_byte = 8'h00;
    status_byte[iopd_pkg::STAT_JMP_A_BIT] = ja;
    status_byte[iopd_pkg::STAT_JMP_B_BIT] = jb;
    status_byte[iopd_pkg::STAT_IRQ_BIT] = irq;
  end

  // ----------------------------------------
  // drive selection latch and outputs
  // ----------------------------------------
  logic [7:0] drive_r, drive_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic [8:0] sel_n_r, sel_n_nxt;
  always_comb begin
    // all eight bits are kept; only the low four leave as drive selects
    drive_nxt = drive_r;
    if (io_write_strobe && p3) begin
      drive_nxt = d[7:0];
    end
    // offset 1 and a mismatch leave the bus idle
    oe_nxt = io_read_strobe && (p2 || p3);
    dout_nxt = '0;
    if (io_read_strobe && p2) begin
      dout_nxt[7:0] = status_byte;
    end else if (io_read_strobe && p3) begin
      dout_nxt[7:0] = drive_r;
    end
    sel_n_nxt = {!match, !fmt, !p0, !p2, !p3, !io_read_strobe, !io_write_strobe, !(io_read_strobe && fmt), !(io_write_strobe && fmt)};
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      drive_r <= iopd_pkg::DRIVE_SEL_RST;
      dout_r <= '0;
      oe_r <= 1'b0;
      sel_n_r <= '1;
    end else begin
      drive_r <= drive_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      sel_n_r <= sel_n_nxt;
    end
  end
  // one clock of latency past the synchroniser: master must allow settling
  assign match_n_o = sel_n_r[8];
  assign formatter_cs_n_o = sel_n_r[7];
  assign dma_ce_n_o = sel_n_r[6];
  assign status_port_select_n_o = sel_n_r[5];
  assign drive_select_port_select_n_o = sel_n_r[4];
  assign io_read_strobe_n_o = sel_n_r[3];
  assign io_write_strobe_n_o = sel_n_r[2];
  assign formatter_read_enable_n_o = sel_n_r[1];
  assign formatter_write_enable_n_o = sel_n_r[0];
  assign data_o = dout_r;
  assign data_oe_o = oe_r;
  assign drive_sel_o = drive_r[iopd_pkg::DRIVE_SELECTS-1:0];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // each output is one register past the decode, so checks look one edge ahead
  a_match_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    match |=> !match_n_o)
    else $error("match not flagged");
  a_match_miss: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !match |=> match_n_o)
    else $error("match flagged on a foreign address");
  a_window_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!formatter_cs_n_o || !dma_ce_n_o || !status_port_select_n_o
      || !drive_select_port_select_n_o) |-> !match_n_o)
    else $error("select outside the eight port window");

  // chip and port selects
  a_fmt_cs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (match && a[2]) |=> (!formatter_cs_n_o && dma_ce_n_o))
    else $error("fmt cs");
  a_fmt_cs_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !fmt |=> formatter_cs_n_o)
    else $error("formatter selected without a match on bit 2");
  a_port_dec: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    p0 |=> (!dma_ce_n_o && status_port_select_n_o))
    else $error("port0 decode");
  a_port_two: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    p2 |=> (!status_port_select_n_o && dma_ce_n_o && drive_select_port_select_n_o))
    else $error("status_port_select decode");
  a_port_three: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    p3 |=> (!drive_select_port_select_n_o && dma_ce_n_o && status_port_select_n_o))
    else $error("drive_select_port_select decode");
  a_dma_ce: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !dma_ce_n_o |-> $past(a[1:0]) == 2'h0)
    else $error("dma ce");

  // strobes
  a_strobes: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !io_read_strobe_n_o |-> $past(io_read_strobe))
    else $error("read strobe");
  a_write_strobe: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !io_write_strobe_n_o |-> $past(io_write_strobe))
    else $error("write strobe without request and write");
  a_fmt_read_en: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (io_read_strobe && fmt) |=> !formatter_read_enable_n_o)
    else $error("formatter read enable missing");
  a_fmt_write_en: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (io_write_strobe && fmt) |=> !formatter_write_enable_n_o)
    else $error("formatter write enable missing");

  // data bus and drive latch
  a_status_drv: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (io_read_strobe && p2) |=> (data_oe_o && data_o[7:0] == $past(status_byte)))
    else $error("stat");
  a_oe_source: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    data_oe_o |-> $past(io_read_strobe))
    else $error("data bus driven outside a read");
  a_drive_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (io_write_strobe && p3) |=> drive_sel_o == $past(d[3:0]))
    else $error("drive load");
  a_drive_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(io_write_strobe && p3) |=> $stable(drive_r))
    else $error("drive latch changed without a port 3 write");
  a_drive_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (io_read_strobe && p3) |=> data_o[7:0] == $past(drive_r))
    else $error("drive read");
  a_status_bits: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (io_read_strobe && p2) |=> (data_o[iopd_pkg::STAT_JMP_A_BIT] == $past(ja)
      && data_o[iopd_pkg::STAT_JMP_B_BIT] == $past(jb)
      && data_o[iopd_pkg::STAT_IRQ_BIT] == $past(irq) && data_o[6:2] == 5'h00))
    else $error("status byte layout");
  a_idle_bus: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!match || a[2:0] == 3'h1) |=> (!data_oe_o && dma_ce_n_o))
    else $error("idle");
  a_unused_port: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (match && !a[iopd_pkg::FMT_SEL_BIT] && a[1:0] == iopd_pkg::PORT_UNUSED)
      |=> (dma_ce_n_o && status_port_select_n_o && drive_select_port_select_n_o
      && formatter_cs_n_o && !data_oe_o))
    else $error("unused port selected something");

  // main scenarios
  c_status_read: cover property (@(posedge sys_clk_i) io_read_strobe && p2);
  c_drive_write: cover property (@(posedge sys_clk_i) io_write_strobe && p3);
  c_fmt_access: cover property (@(posedge sys_clk_i) fmt && io_read_strobe);
  c_drive_read: cover property (@(posedge sys_clk_i) io_read_strobe && p3);
  c_foreign_read: cover property (@(posedge sys_clk_i) !match && io_read_strobe);
endmodule : iopd_decoder

//--- tb/iopd_master.sv
`timescale 1ns/100ps
module iopd_master (
  output logic [7:0] addr_o,
  input wire logic sys_clk_i,
  output logic io_req_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] data_o
);
  initial begin
    addr_o = 8'h00;
    data_o = 8'h00;
    idle();
  end
  // released data lines show the inverse so a stale byte never passes
  task automatic idle();
    io_req_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = ~data_o;
  endtask : idle
  task automatic cyc(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    addr_o = a;
    data_o = d;
    repeat (3) @(negedge sys_clk_i);
    io_req_n_o = 1'b0;
    rd_n_o = ~rd;
    wr_n_o = rd;
    repeat (4) @(negedge sys_clk_i);
  endtask : cyc
endmodule : iopd_master

//--- tb/io_port_address_decoder_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module io_port_address_decoder_tb;
  logic sys_clk_i, rst_i, req_n, rd_n, wr_n, ja, jb, irq, oe;
  logic [7:0] addr, wdat, rdat;
  logic [4:0] strap;
  logic [3:0] dsel;
  logic m_n, fcs_n, dma_n, st_n, dr_n, ird_n, iwr_n, fre_n, fwe_n;
  int fails, n_compared, cycles;
  iopd_master mst_u (.addr_o(addr), .sys_clk_i(sys_clk_i), .io_req_n_o(req_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(wdat));
  iopd_decoder dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr),
    .io_req_n_i(req_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(wdat),
    .base_address_strap_i(strap), .config_jumper_a_i(ja), .config_jumper_b_i(jb),
    .formatter_completion_request_i(irq), .match_n_o(m_n), .formatter_cs_n_o(fcs_n),
    .dma_ce_n_o(dma_n), .status_port_select_n_o(st_n), .drive_select_port_select_n_o(dr_n),
    .io_read_strobe_n_o(ird_n), .io_write_strobe_n_o(iwr_n),
    .formatter_read_enable_n_o(fre_n), .formatter_write_enable_n_o(fwe_n),
    .data_o(rdat), .data_oe_o(oe), .drive_sel_o(dsel));
  task automatic final_report();
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // every offset of the block read once; selects and strobes as one vector
  task automatic t_map();
    logic [2:0] o;
    for (int i = 0; i < 8; i++) begin
      o = i[2:0];
      mst_u.cyc(1'b1, {5'h15, o}, 8'h00);
      `CHK("selects", {1'b0, ~o[2], o != 3'h0, o != 3'h2, o != 3'h3, 1'b0, ~o[2],
        o == 3'h2 || o == 3'h3}, {m_n, fcs_n, dma_n, st_n, dr_n, ird_n, fre_n, oe})
      mst_u.idle();
    end
  endtask : t_map
  task automatic t_drive();
    `CHK("drive reset", 4'h0, dsel)
    mst_u.cyc(1'b0, 8'hab, 8'h5a);
    `CHK("write", 4'h6, {iwr_n, fwe_n, dsel[3:2]})
    `CHK("drive sel", 4'ha, dsel)
    mst_u.idle();
    mst_u.cyc(1'b1, 8'hab, 8'h00);
    `CHK("readback", 9'h15a, {oe, rdat})
    mst_u.idle();
  endtask : t_drive
  // writes to the formatter and the dma port must leave the drive latch alone
  task automatic t_write();
    mst_u.cyc(1'b0, 8'hac, 8'h33);
    `CHK("fmt write", 8'h1a, {fcs_n, iwr_n, fwe_n, fre_n, dsel})
    mst_u.idle();
    mst_u.cyc(1'b0, 8'ha8, 8'h44);
    `CHK("dma write", 7'h2a, {dma_n, fwe_n, iwr_n, dsel})
    mst_u.idle();
  endtask : t_write
  // a reset in mid-run clears the drive latch and leaves every select idle
  task automatic t_reset();
    rst_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    `CHK("reset selects", 9'h1ff, {m_n, fcs_n, dma_n, st_n, dr_n, ird_n, iwr_n, fre_n, fwe_n})
    `CHK("reset data", 5'h00, {oe, dsel})
    rst_i = 1'b0;
  endtask : t_reset
  task automatic t_status(input logic a, input logic b, input logic q, input logic [7:0] e);
    @(negedge sys_clk_i);
    {ja, jb, irq} = {a, b, q};
    mst_u.cyc(1'b1, 8'haa, 8'h00);
    `CHK("status", {1'b1, e}, {oe, rdat})
    mst_u.idle();
  endtask : t_status
  task automatic t_miss();
    strap = 5'h14;
    mst_u.cyc(1'b1, 8'hab, 8'h00);
    `CHK("miss", 3'h6, {m_n, dr_n, oe})
    mst_u.idle();
    strap = 5'h15;
  endtask : t_miss
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    {rst_i, ja, jb, irq, strap} = {4'h8, 5'h15};
    repeat (6) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_map();
    t_drive();
    t_write();
    t_reset();
    t_status(1'b1, 1'b0, 1'b1, 8'h81);
    t_status(1'b0, 1'b1, 1'b0, 8'h02);
    t_miss();
    final_report();
  end
endmodule : io_port_address_decoder_tb
